// [rtl/puc_top.sv]
// protection unit control: banked control register, access decision, fault events
// How it works
// - global enable low: no region checks, default map as if absent.
// - enabled without background map: outside every enabled region faults.
// - enabled with background map: privileged misses use the default map.
// - any matching enabled region outranks the background map.
// - background map bit ignored while globally disabled.
// - handler enable low: no checks in escalated fault and NMI handlers.
// - priorities -1, -2, -3 bypass unless handler enable is one.
// - system control space always no-execute, strongly ordered device.
// - while enabled, vector table and non-fetch system control space accesses always allowed.
// - background map with no region: only privileged accesses pass.
// - disabled default map treats privileged and unprivileged alike.
// - one control register copy per security state, chosen by access.
// - hit on two or more enabled regions faults.
// - denied access raises the memory access fault exception.
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
module puc_top #(
    parameter int NREG = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [puc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // core access, same clock
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_priv,
    input wire logic acc_secure,
    input wire logic acc_fetch,
    input wire logic signed [puc_pkg::PRIO_W-1:0] acc_prio,
    input wire logic [31:0] vtor_base,
    input wire logic [NREG-1:0] region_hit,
    input wire logic [NREG-1:0] region_allow,
    // result to core, one cycle after the access
    output logic res_valid,
    output puc_pkg::puc_dec_e res_dec,
    output logic res_no_execute_attribute,
    output logic res_strongly_ordered_device_type,
    output logic memory_access_fault_exception,
    output logic ctrl_enable_s,
    output logic ctrl_enable_ns,
    // interrupt
    output logic irq
);
    import puc_pkg::*;

    // ============================================================
    // bus decode
    logic [CTRL_W-1:0] ctrl_s_r;
    logic [CTRL_W-1:0] ctrl_ns_r;
    logic [EVT_W-1:0] evt_status_r;
    logic [EVT_W-1:0] evt_mask_r;
    logic ack_r;
    logic err_r;
    logic [31:0] rdat_r;

    wire bus_req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
    wire sel_ctrl_s = (wb_adr_i == ADDR_CTRL_S);
    wire sel_ctrl_ns = (wb_adr_i == ADDR_CTRL_NS);
    wire sel_status = (wb_adr_i == ADDR_IRQ_STATUS);
    wire sel_mask = (wb_adr_i == ADDR_IRQ_MASK);
    wire mapped = sel_ctrl_s || sel_ctrl_ns || sel_status || sel_mask;
    wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0] && mapped;
    wire wr_ctrl_s = wr_lane0 && sel_ctrl_s;
    wire wr_ctrl_ns = wr_lane0 && sel_ctrl_ns;
    wire wr_status = wr_lane0 && sel_status;
    wire wr_mask = wr_lane0 && sel_mask;

    // upper bits read zero, writes to them dropped
    wire [31:0] rd_mux = sel_ctrl_s ? {29'h0, ctrl_s_r} :
                         sel_ctrl_ns ? {29'h0, ctrl_ns_r} :
                         sel_status ? {30'h0, evt_status_r} :
                         sel_mask ? {30'h0, evt_mask_r} : 32'h0;

    // ============================================================
    // control registers, one per security state
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_s_r <= CTRL_RESET;
            ctrl_ns_r <= CTRL_RESET;
        end else begin
            if (wr_ctrl_s) begin
                ctrl_s_r <= wb_dat_i[CTRL_W-1:0];
            end
            if (wr_ctrl_ns) begin
                ctrl_ns_r <= wb_dat_i[CTRL_W-1:0];
            end
        end
    end

    // ============================================================
    // bus answer: one cycle after the request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= bus_req && mapped;
            err_r <= bus_req && !mapped;
            rdat_r <= (bus_req && mapped) ? rd_mux : 32'h0;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_err_o = err_r;
    assign wb_dat_o = rdat_r;

    // ============================================================
    // access decision
    wire [CTRL_W-1:0] ctrl_sel = acc_secure ? ctrl_s_r : ctrl_ns_r;
    wire [31:0] vtor_end = vtor_base + 32'(VTOR_SPAN - 1);
    wire in_scs = (acc_addr >= SCS_BASE) && (acc_addr <= SCS_LIMIT);
    wire in_vtor = (acc_addr >= vtor_base) && (acc_addr <= vtor_end);
    wire sys_area = in_scs || in_vtor;

    puc_dec_e dec;
    logic deny;
    logic overlap;

    puc_check #(
        .NREG(NREG)
    ) u_check (
        .ctrl(ctrl_sel),
        .priv(acc_priv),
        .prio(acc_prio),
        .sys_area(sys_area),
        .region_hit(region_hit),
        .region_allow(region_allow),
        .dec(dec),
        .deny(deny),
        .overlap(overlap)
    );

    // a fetch from the control space is itself a denial
    wire scs_fetch = in_scs && acc_fetch;
    wire fault_now = acc_valid && (deny || scs_fetch);
    wire overlap_now = acc_valid && overlap;

    logic res_valid_r;
    puc_dec_e res_dec_r;
    logic xn_r;
    logic so_r;
    logic fault_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            res_valid_r <= 1'b0;
            res_dec_r <= PUC_DEC_DEFAULT;
            xn_r <= 1'b0;
            so_r <= 1'b0;
            fault_r <= 1'b0;
        end else begin
            res_valid_r <= acc_valid;
            res_dec_r <= scs_fetch ? PUC_DEC_FAULT : dec;
            xn_r <= acc_valid && in_scs;
            so_r <= acc_valid && in_scs;
            fault_r <= fault_now;
        end
    end

    assign res_valid = res_valid_r;
    assign res_dec = res_dec_r;
    assign res_no_execute_attribute = xn_r;
    assign res_strongly_ordered_device_type = so_r;
    assign memory_access_fault_exception = fault_r;
    assign ctrl_enable_s = ctrl_s_r[CTRL_ENABLE_BIT];
    assign ctrl_enable_ns = ctrl_ns_r[CTRL_ENABLE_BIT];

    // ============================================================
    // sticky events, write one to clear, set wins over clear
    wire [EVT_W-1:0] evt_set = {overlap_now, fault_now};
    wire [EVT_W-1:0] evt_clr = wr_status ? wb_dat_i[EVT_W-1:0] : EVT_RESET;
    wire [EVT_W-1:0] evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;
    logic irq_r;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            evt_status_r <= EVT_RESET;
            evt_mask_r <= EVT_RESET;
            irq_r <= 1'b0;
        end else begin
            evt_status_r <= evt_status_nxt;
            if (wr_mask) begin
                evt_mask_r <= wb_dat_i[EVT_W-1:0];
            end
            irq_r <= |(evt_status_nxt & (wr_mask ? wb_dat_i[EVT_W-1:0] : evt_mask_r));
        end
    end

    assign irq = irq_r;

endmodule : puc_top

// [rtl/puc_pkg.sv]
// package: constants, register layout and types of the protection unit control block
package puc_pkg;

    // ============================================================
    // register map (word byte addresses)
    localparam logic [3:0] ADDR_CTRL_S = 4'h0;
    localparam logic [3:0] ADDR_CTRL_NS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    localparam int ADDR_W = 4;

    // ============================================================
    // control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_HPH_BIT = 1;
    localparam int CTRL_BGMAP_BIT = 2;
    localparam int CTRL_W = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // ============================================================
    // event status fields
    localparam int EVT_DENY_BIT = 0;
    localparam int EVT_OVERLAP_BIT = 1;
    localparam int EVT_W = 2;
    localparam logic [1:0] EVT_RESET = 2'h0;

    // ============================================================
    // execution priorities that bypass checking (-1, -2, -3 as 9-bit signed)
    localparam int PRIO_W = 9;
    localparam logic signed [8:0] PRIO_BYPASS_HI = -9'sh001;
    localparam logic signed [8:0] PRIO_BYPASS_LO = -9'sh003;

    // ============================================================
    // fixed system areas
    localparam logic [31:0] SCS_BASE = 32'hE000E000;
    localparam logic [31:0] SCS_LIMIT = 32'hE000EFFF;
    localparam int VTOR_SPAN = 1024;

    // ============================================================
    // decision taken for one access
    typedef enum logic [1:0] {
        PUC_DEC_DEFAULT = 2'h0,
        PUC_DEC_REGION = 2'h1,
        PUC_DEC_ALLOW = 2'h3,
        PUC_DEC_FAULT = 2'h2
    } puc_dec_e;

endpackage : puc_pkg

// [rtl/puc_check.sv]
// combinational access decision for one bank of control bits
`timescale 1ns/1ns
module puc_check #(
    parameter int NREG = 8
) (
    // control bank
    input wire logic [puc_pkg::CTRL_W-1:0] ctrl,
    // access
    input wire logic priv,
    input wire logic signed [puc_pkg::PRIO_W-1:0] prio,
    input wire logic sys_area,
    input wire logic [NREG-1:0] region_hit,
    input wire logic [NREG-1:0] region_allow,
    // result
    output puc_pkg::puc_dec_e dec,
    output logic deny,
    output logic overlap
);
    import puc_pkg::*;

    wire en = ctrl[CTRL_ENABLE_BIT];
    wire bgmap = ctrl[CTRL_BGMAP_BIT];
    wire hph = ctrl[CTRL_HPH_BIT];
    wire hi_prio = (prio >= PRIO_BYPASS_LO) && (prio <= PRIO_BYPASS_HI);
    wire bypass = hi_prio && !hph;
    wire active = en && !bypass;
    wire any_hit = |region_hit;
    wire multi_hit = any_hit && |(region_hit & (region_hit - NREG'(1)));
    wire hit_ok = |(region_hit & region_allow);
    wire bg_ok = bgmap && priv;

    assign overlap = active && !sys_area && multi_hit;
    // a matching region decides before the background map
    assign deny = active && !sys_area &&
                  (multi_hit || (any_hit ? !hit_ok : !bg_ok));
    assign dec = !active ? PUC_DEC_DEFAULT :
                 sys_area ? PUC_DEC_ALLOW :
                 deny ? PUC_DEC_FAULT :
                 any_hit ? PUC_DEC_REGION : PUC_DEC_DEFAULT;
endmodule : puc_check

// [testbench/puc_checker.sv]
// port checker for the protection unit control top
`timescale 1ns/1ns
module puc_checker #(
    parameter int NREG = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // access and result
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic acc_secure,
    input wire logic acc_fetch,
    input wire logic signed [puc_pkg::PRIO_W-1:0] acc_prio,
    input wire logic [31:0] vtor_base,
    input wire logic [NREG-1:0] region_hit,
    input wire logic [NREG-1:0] region_allow,
    input wire logic res_valid,
    input wire puc_pkg::puc_dec_e res_dec,
    input wire logic res_no_execute_attribute,
    input wire logic res_strongly_ordered_device_type,
    input wire logic memory_access_fault_exception,
    input wire logic ctrl_enable_s,
    input wire logic ctrl_enable_ns
);
    import puc_pkg::*;
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire logic scs = acc_addr >= SCS_BASE && acc_addr <= SCS_LIMIT;
    wire logic vt = (acc_addr - vtor_base) < 32'(VTOR_SPAN);
    wire logic en = acc_secure ? ctrl_enable_s : ctrl_enable_ns;
    wire logic pos = acc_valid && !acc_fetch && !acc_prio[PRIO_W-1];
    wire logic chk = pos && !scs && !vt;
    wire logic multi = $countones(region_hit) > 1;
    wire logic one_ok = $onehot(region_hit) && |(region_hit & region_allow);
    // ============================================================
    // properties
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_answer: assert property (req |=> wb_ack_o || wb_err_o)
        else $error("no bus answer");
    chk_off_default: assert property (chk && !en |=> res_dec == PUC_DEC_DEFAULT)
        else $error("disabled not default");
    chk_overlap_fault: assert property (chk && en && multi |=> res_dec == PUC_DEC_FAULT)
        else $error("overlap not fault");
    chk_region_wins: assert property (chk && en && one_ok |=> res_dec == PUC_DEC_REGION)
        else $error("region not used");
    chk_fault_raise: assert property (res_valid && res_dec == PUC_DEC_FAULT |->
        memory_access_fault_exception) else $error("fault not raised");
    chk_scs_attr: assert property (acc_valid && scs |=>
        res_no_execute_attribute && res_strongly_ordered_device_type) else $error("scs attr");
    chk_sys_allow: assert property (pos && en && (scs || vt) |=> res_dec == PUC_DEC_ALLOW)
        else $error("sys area refused");
endmodule : puc_checker

bind puc_top puc_checker #(.NREG(NREG)) u_puc_checker (.*);

// [testbench/puc_core_model.sv]
// core model issuing one tagged access at a time
`timescale 1ns/1ns
module puc_core_model (
    // clock
    input wire logic clk_sys,
    // access
    output logic acc_valid,
    output logic [31:0] acc_addr,
    output logic acc_priv,
    output logic acc_secure,
    output logic acc_fetch,
    output logic signed [puc_pkg::PRIO_W-1:0] acc_prio,
    output logic [7:0] region_hit,
    output logic [7:0] region_allow,
    // answer
    input wire puc_pkg::puc_dec_e res_dec,
    input wire logic memory_access_fault_exception
);
    import puc_pkg::*;
    initial begin
        acc_valid = 1'h0;
        {acc_addr, acc_priv, acc_secure, acc_fetch, acc_prio, region_hit, region_allow} = '0;
    end
    // f is {privileged, secure, fetch}; the idle address line shows the inverse
    task automatic issue(input logic [31:0] a, input logic [2:0] f, input logic [8:0] p,
                         input logic [7:0] h, input logic [7:0] ok,
                         output logic [1:0] dec, output logic flt);
        @(posedge clk_sys);
        acc_valid <= 1'h1;
        acc_addr <= a;
        {acc_priv, acc_secure, acc_fetch} <= f;
        acc_prio <= p;
        region_hit <= h;
        region_allow <= ok;
        @(posedge clk_sys);
        acc_valid <= 1'h0;
        acc_addr <= ~a;
        // answer launched at the edge above is settled by the falling edge
        @(negedge clk_sys);
        dec = res_dec;
        flt = memory_access_fault_exception;
    endtask : issue
endmodule : puc_core_model

// [testbench/testbench.sv]
// self-checking bench for the protection unit control block
`timescale 1ns/1ns
module testbench;
    import puc_pkg::*;
    localparam logic [31:0] RAM = 32'h20000000;
    logic clk_sys, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, acc_addr, vtor_base, q;
    logic acc_valid, acc_priv, acc_secure, acc_fetch, res_valid, e, i0, flt;
    logic res_no_execute_attribute, res_strongly_ordered_device_type;
    logic memory_access_fault_exception, ctrl_enable_s, ctrl_enable_ns;
    logic signed [PRIO_W-1:0] acc_prio;
    logic [7:0] region_hit, region_allow;
    logic [1:0] d;
    puc_dec_e res_dec;
    int mismatches, comparisons, cycles;
    puc_top #(.NREG(8)) u_puc_top (.*);
    puc_core_model u_puc_core_model (.*);
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] x);
        comparisons++;
        if (seen !== x) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", n, x, seen);
        end
    endtask : check
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        do @(posedge clk_sys); while (!(wb_ack_o || wb_err_o));
        q = wb_dat_o;
        e = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] x);
        wb(1'h0, a, 32'h0);
        check("read", q, x);
    endtask : rd
    task automatic acc(input string n, input logic [31:0] a, input logic [2:0] f,
                       input logic [8:0] p, input logic [7:0] h, input logic [7:0] ok,
                       input puc_dec_e x);
        u_puc_core_model.issue(a, f, p, h, ok, d, flt);
        check(n, d, x);
        check(n, flt, x == PUC_DEC_FAULT);
    endtask : acc
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        arst_n = 1'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        vtor_base = 32'h00001000;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'h1;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        acc("off", RAM, 3'h2, 9'h0, 8'h0, 8'h0, PUC_DEC_DEFAULT);
        wb(1'h1, 4'h0, 32'h4);
        acc("bg off", RAM, 3'h2, 9'h0, 8'h0, 8'h0, PUC_DEC_DEFAULT);
        u_puc_core_model.issue(SCS_BASE, 3'h2, 9'h0, 8'h0, 8'h0, d, flt);
        check("scs off", d, PUC_DEC_DEFAULT);
        wb(1'h1, 4'h0, 32'hFFFFFFFF);
        rd(4'h0, 32'h7);
        check("enable s", ctrl_enable_s, 32'h1);
        check("enable ns", ctrl_enable_ns, 32'h0);
        rd(4'h4, 32'h0);
        acc("ns", RAM, 3'h0, 9'h0, 8'h0, 8'h0, PUC_DEC_DEFAULT);
        acc("bg user", RAM, 3'h2, 9'h0, 8'h0, 8'h0, PUC_DEC_FAULT);
        acc("bg priv", RAM, 3'h6, 9'h0, 8'h0, 8'h0, PUC_DEC_DEFAULT);
        acc("bg deny", RAM, 3'h6, 9'h0, 8'h1, 8'h0, PUC_DEC_FAULT);
        wb(1'h1, 4'h0, 32'h1);
        acc("miss", RAM, 3'h6, 9'h0, 8'h0, 8'h0, PUC_DEC_FAULT);
        acc("hit", RAM, 3'h6, 9'h0, 8'h4, 8'h4, PUC_DEC_REGION);
        acc("two", RAM, 3'h6, 9'h0, 8'h6, 8'h6, PUC_DEC_FAULT);
        acc("scs", SCS_LIMIT, 3'h2, 9'h0, 8'h0, 8'h0, PUC_DEC_ALLOW);
        acc("vt", 32'h000013FC, 3'h2, 9'h0, 8'h0, 8'h0, PUC_DEC_ALLOW);
        for (int p = 1; p <= 3; p++) begin
            acc("hp off", RAM, 3'h6, 9'(-p), 8'h0, 8'h0, PUC_DEC_DEFAULT);
        end
        wb(1'h1, 4'h0, 32'h3);
        for (int p = 1; p <= 3; p++) begin
            acc("hp on", RAM, 3'h6, 9'(-p), 8'h0, 8'h0, PUC_DEC_FAULT);
        end
        rd(4'h8, 32'h3);
        wb(1'h1, 4'hC, 32'h0);
        rd(4'hC, 32'h0);
        i0 = irq;
        wb(1'h1, 4'hC, 32'h3);
        rd(4'hC, 32'h3);
        check("irq mask", i0 ^ irq, 32'h1);
        wb(1'h1, 4'h8, 32'h3);
        rd(4'h8, 32'h0);
        check("irq clear", irq, 32'h0);
        wb(1'h0, 4'h2, 32'h0);
        check("unmapped", e, 32'h1);
        wrap_up();
    end
endmodule : testbench
